/* File: rtl/fault_sup_params.svh */
// constants of the pixel fault supervisor
// assumes inclusion by the package and by the supervisor module
`ifndef FAULT_SUP_PARAMS_SVH
`define FAULT_SUP_PARAMS_SVH

`define FS_FRAME_BITS    6'h20
`define FS_ST_OFF        3'h0
`define FS_ST_SHORT      3'h1
`define FS_ST_OPEN       3'h2
`define FS_ST_ON         3'h7
`define FS_STRINGS       4
`define FS_SWITCHES      12

`endif

/* File: rtl/fault_sup_pkg.sv */
// types shared by the pixel fault supervisor
// assumes the params header sits beside it
`include "fault_sup_params.svh"
package fault_sup_pkg;

  // one-cycle read-clear strobes, one per readable flag
  typedef struct packed {
    logic                    thermal_warning;
    logic                    overheat_shutdown;
    logic                    frame_check;
    logic                    on_overlap;
    logic                    off_overlap;
    logic [`FS_STRINGS-1:0]  ground_loss;
    logic                    overvoltage;
    logic                    counter_wrap;
    logic                    charge_cap;
    logic                    powerup;
  } read_clear_t;

  // latched flags, same layout as the clear strobes
  typedef read_clear_t flags_t;

  typedef enum logic [1:0] {RUN, TRIPPED, RECOVER} sup_state_t;

endpackage : fault_sup_pkg

/* File: rtl/pixel_fault_supervisor.sv */
// pixel fault supervisor: latches faults, drives fail pin and switch kill
// assumes sensor inputs are asynchronous pins; strobes are on clock
//
// Contract
// - warning flag set hot, cleared on read
// - shutdown flag held until read and cool
// - shutdown releases fail, switches off
// - resume only when cool and flags clear
// - compare output readable, threshold three bits
// - frame error on non-32 bits or crc
// - on overlap: error, fail, off, stop
// - off overlap: warning flag only
// - global fault carried in response status
// - global fault releases fail, switches off
// - per switch state and fault code
// - ground loss flagged only when enabled
// - ground loss: fault, fail, off, disable
// - overvoltage: flag, fault, fail, off, disable
// - counter wrap sets read-clear flag
// - cap charge fail: flag, fault, fail, off
// - powerup flag set after reset
// - fault codes 000 001 010 111
// - global fault is or of faults
// - powerup flag cleared on read
// - on overlap also clears drive enable
`timescale 1ns/1ps
`default_nettype none
`include "fault_sup_params.svh"
module pixel_fault_supervisor #(
  parameter int NSW = `FS_SWITCHES
) (
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  input  wire logic                        temp_warn_pin,
  input  wire logic                        temp_shut_pin,
  input  wire logic                        temp_cmp_pin,
  input  wire logic [2:0]                  heat_compare_threshold,
  input  wire logic                        chip_select_n,
  input  wire logic                        frame_bit_strobe,
  input  wire logic                        crc_fail_strobe,
  input  wire logic                        on_overlap_strobe,
  input  wire logic                        off_overlap_strobe,
  input  wire logic [NSW-1:0]              sw_short_pin,
  input  wire logic [NSW-1:0]              sw_open_pin,
  input  wire logic [NSW-1:0]              sw_overcur_pin,
  input  wire logic [NSW-1:0]              sw_gate_on,
  input  wire logic [`FS_STRINGS-1:0]      string_ground_check_en,
  input  wire logic [`FS_STRINGS-1:0]      ground_loss_pin,
  input  wire logic [`FS_STRINGS-1:0]      string_ov_pin,
  input  wire logic                        dimming_counter_wrap,
  input  wire logic                        cap_fail_pin,
  input  wire logic                        supervise_en,
  input  wire logic                        drive_enable_set,
  input  wire fault_sup_pkg::read_clear_t  read_clear,
  output logic                             die_heat_compare_out,
  output logic [2:0]                       threshold_sel,
  output fault_sup_pkg::flags_t            flags,
  output logic                             global_switch_fault,
  output logic                             status_fault_bit,
  output logic [NSW-1:0]                   switch_conducting_state,
  output logic [NSW*3-1:0]                 switch_fault_state,
  output logic                             switch_drive_enable,
  output logic                             switches_off,
  output logic                             pattern_stop,
  output logic                             fail_o,
  output logic                             fail_oe_n
);
  import fault_sup_pkg::*;

  localparam int NA = 3 + 3 * NSW + 2 * `FS_STRINGS + 1; // async pin count

  typedef struct packed {
    logic [NA-1:0]           s1;
    logic [NA-1:0]           s2;
    logic [5:0]              bitcnt;
    logic                    cs_q;
    flags_t                  fl;
    logic                    gsw;
    logic                    drv_en;
    logic                    off;
    logic                    stop;
    logic                    fail_oe_n;
    logic                    cmp;
    logic [2:0]              thr;
    logic [NSW-1:0]          cond;
    logic [NSW*3-1:0]        code;
    sup_state_t              st;
  } state_t;

  state_t q, d;
  logic [NA-1:0] raw;
  logic          tw, overheat_shutdown_flag, tcmp, capf;
  logic [NSW-1:0] shr, opn, ovc;
  logic [`FS_STRINGS-1:0] gnd, sov;
  logic          gsw_now, shut_now, frame_err;
  logic [NSW*3-1:0] code_now;

  assign raw = {temp_warn_pin, temp_shut_pin, temp_cmp_pin, sw_short_pin,
                sw_open_pin, sw_overcur_pin, ground_loss_pin, string_ov_pin,
                cap_fail_pin};
  // only the second sync stage is ever decoded
  assign {tw, overheat_shutdown_flag, tcmp, shr, opn, ovc, gnd, sov, capf} = q.s2;

  // per switch fault code, short beats open
  genvar g;
  generate
    for (g = 0; g < NSW; g++) begin : g_code
      assign code_now[g*3 +: 3] = shr[g] ? `FS_ST_SHORT :
                                  opn[g] ? `FS_ST_OPEN :
                                  sw_gate_on[g] ? `FS_ST_ON : `FS_ST_OFF;
    end
  endgenerate

  // frame length checked at chip select release
  assign frame_err = crc_fail_strobe ||
                     (chip_select_n && !q.cs_q && q.bitcnt != `FS_FRAME_BITS);

  always_comb begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    d.cs_q = chip_select_n;
    if (chip_select_n) d.bitcnt = '0;
    else if (frame_bit_strobe && q.bitcnt != 6'h3f)
      d.bitcnt = q.bitcnt + 6'h01; // saturates so long frames still fail
    // set wins over read clear on every sticky flag
    d.fl = q.fl & ~read_clear;
    if (tw) d.fl.thermal_warning = 1'b1;
    // shutdown clears only when read and the condition is gone
    if (overheat_shutdown_flag) d.fl.overheat_shutdown = 1'b1;
    if (frame_err) d.fl.frame_check = 1'b1;
    if (on_overlap_strobe) d.fl.on_overlap = 1'b1;
    if (off_overlap_strobe) d.fl.off_overlap = 1'b1;
    d.fl.ground_loss = d.fl.ground_loss | (gnd & string_ground_check_en);
    if (|sov) d.fl.overvoltage = 1'b1;
    if (dimming_counter_wrap) d.fl.counter_wrap = 1'b1;
    if (capf) d.fl.charge_cap = 1'b1;
    // global fault from live switch faults and latched string and cap flags
    gsw_now = (|shr) | (|opn) | (|ovc) |
              (|(q.fl.ground_loss & string_ground_check_en)) |
              q.fl.charge_cap | q.fl.overvoltage;
    d.gsw = gsw_now;
    shut_now = gsw_now | q.fl.overheat_shutdown | q.fl.on_overlap;
    // shutting faults that also drop the drive enable
    if (q.fl.overheat_shutdown || q.fl.on_overlap ||
        (|q.fl.ground_loss) || q.fl.overvoltage)
      d.drv_en = 1'b0;
    else if (drive_enable_set && q.st == RUN)
      d.drv_en = 1'b1;
    d.stop = q.fl.on_overlap ? 1'b1 : (q.drv_en ? q.stop : 1'b0);
    case (q.st)
      RUN:
        if (shut_now || !supervise_en) d.st = TRIPPED;
      TRIPPED:
        if (!shut_now && supervise_en) d.st = RECOVER;
      RECOVER: begin
        // hysteresis: wait below warning level with both flags clear
        if (shut_now || !supervise_en) d.st = TRIPPED;
        else if (!tw && !q.fl.thermal_warning && !q.fl.overheat_shutdown)
          d.st = RUN;
      end
      default: d.st = TRIPPED;
    endcase
    d.off = (d.st != RUN) || !d.drv_en;
    d.fail_oe_n = (d.st != RUN);
    d.cmp = tcmp;
    d.thr = heat_compare_threshold;
    d.cond = sw_gate_on & ~d.off;
    d.code = code_now;
  end

  // powerup flag set by the reset itself
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.fl.powerup <= 1'b1;
      q.st <= TRIPPED;
      q.off <= 1'b1;
      q.fail_oe_n <= 1'b1;
      q.cs_q <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign die_heat_compare_out    = q.cmp;
  assign threshold_sel           = q.thr;
  assign flags                   = q.fl;
  assign global_switch_fault     = q.gsw;
  assign status_fault_bit        = q.gsw;
  assign switch_conducting_state = q.cond;
  assign switch_fault_state      = q.code;
  assign switch_drive_enable     = q.drv_en;
  assign switches_off            = q.off;
  assign pattern_stop            = q.stop;
  assign fail_o                  = 1'b0; // open drain, low when driven
  assign fail_oe_n               = q.fail_oe_n;

  AST_TW_SET: assert property (@(posedge clock) disable iff (!arst_n)
    tw |=> flags.thermal_warning) else $error("warning flag not set");
  AST_TSD_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
    overheat_shutdown_flag |=> flags.overheat_shutdown) else $error("shutdown flag dropped");
  AST_TSD_OFF: assert property (@(posedge clock) disable iff (!arst_n)
    flags.overheat_shutdown |=> switches_off && fail_oe_n)
    else $error("shutdown did not kill switches");
  AST_GSW_OFF: assert property (@(posedge clock) disable iff (!arst_n)
    global_switch_fault |=> switches_off && fail_oe_n)
    else $error("global fault did not kill switches");
  AST_DIM_ERR: assert property (@(posedge clock) disable iff (!arst_n)
    on_overlap_strobe |=> flags.on_overlap ##1 !switch_drive_enable
    ##0 pattern_stop) else $error("on overlap not handled");
  AST_DIM_WARN: assert property (@(posedge clock) disable iff (!arst_n)
    off_overlap_strobe |=> flags.off_overlap)
    else $error("off overlap not flagged");
  AST_CRC: assert property (@(posedge clock) disable iff (!arst_n)
    crc_fail_strobe |=> flags.frame_check) else $error("crc not flagged");
  // every string, not only the first, must be enabled before it latches
  AST_GND_EN: assert property (@(posedge clock) disable iff (!arst_n)
    !(|(flags.ground_loss & ~$past(flags.ground_loss) &
        ~$past(string_ground_check_en))))
    else $error("ground loss flagged while disabled");
  AST_STATUS: assert property (@(posedge clock) disable iff (!arst_n)
    status_fault_bit == global_switch_fault)
    else $error("status bit differs from global fault");
  // state reacts to latched flags one edge late, so look one edge back
  AST_HEALTHY: assert property (@(posedge clock) disable iff (!arst_n)
    !fail_oe_n |-> $past(!global_switch_fault &&
                         !flags.overheat_shutdown && !flags.on_overlap))
    else $error("fail pulled low while faulted");

  // clear on read: a flag may only fall after a read that returned it
  AST_PWR_CLR: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(flags.powerup) |-> $past(read_clear.powerup))
    else $error("powerup flag lost without read");
  AST_WRAP_CLR: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(flags.counter_wrap) |-> $past(read_clear.counter_wrap))
    else $error("wrap flag lost without read");
  AST_FRAME_CLR: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(flags.frame_check) |-> $past(read_clear.frame_check))
    else $error("frame flag lost without read");

  // event flags latch one edge after their source
  AST_WRAP_SET: assert property (@(posedge clock) disable iff (!arst_n)
    dimming_counter_wrap |=> flags.counter_wrap)
    else $error("wrap flag not set");
  AST_CAP_SET: assert property (@(posedge clock) disable iff (!arst_n)
    capf |=> flags.charge_cap)
    else $error("charge fault not flagged");
  AST_OV_SET: assert property (@(posedge clock) disable iff (!arst_n)
    (|sov) |=> flags.overvoltage)
    else $error("overvoltage not flagged");

  // latched cap fault and live switch short feed the global fault
  AST_CAP_GSW: assert property (@(posedge clock) disable iff (!arst_n)
    flags.charge_cap |=> global_switch_fault)
    else $error("charge fault missing from global fault");
  AST_SHORT_GSW: assert property (@(posedge clock) disable iff (!arst_n)
    $past(|shr) |-> global_switch_fault)
    else $error("short missing from global fault");

  // faults that must also drop the drive enable, then on overlap stopping the pattern
  AST_OV_DRV: assert property (@(posedge clock) disable iff (!arst_n)
    flags.overvoltage |=> !switch_drive_enable)
    else $error("overvoltage left drive enabled");
  AST_GND_DRV: assert property (@(posedge clock) disable iff (!arst_n)
    (|flags.ground_loss) |=> !switch_drive_enable)
    else $error("ground loss left drive enabled");
  AST_TSD_DRV: assert property (@(posedge clock) disable iff (!arst_n)
    flags.overheat_shutdown |=> !switch_drive_enable)
    else $error("shutdown left drive enabled");
  AST_STOP: assert property (@(posedge clock) disable iff (!arst_n)
    flags.on_overlap |=> pattern_stop)
    else $error("pattern not stopped");

  // recovery only from a clean thermal state
  AST_RESUME: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(!fail_oe_n) |-> $past(!flags.thermal_warning &&
                                !flags.overheat_shutdown))
    else $error("resumed with thermal flag set");

  // per switch status
  AST_CODE_SHORT: assert property (@(posedge clock) disable iff (!arst_n)
    $past(shr[0]) |-> switch_fault_state[2:0] == `FS_ST_SHORT)
    else $error("short code wrong");
  AST_COND_OFF: assert property (@(posedge clock) disable iff (!arst_n)
    switches_off |-> switch_conducting_state == '0)
    else $error("switch shown on while killed");

  // comparator and threshold echo, one edge behind
  AST_CMP: assert property (@(posedge clock) disable iff (!arst_n)
    die_heat_compare_out == $past(tcmp))
    else $error("compare output not echoed");
  AST_THR: assert property (@(posedge clock) disable iff (!arst_n)
    threshold_sel == $past(heat_compare_threshold))
    else $error("threshold not echoed");
endmodule : pixel_fault_supervisor
`default_nettype wire

/* File: test/host_ecu_model.sv */
// host model: reads flags with clear, sends serial frames
// assumes the bench calls its tasks; drives on the falling edge
`timescale 1ns/1ps
`default_nettype none
// never sends patterns with overlapping on events
module host_ecu_model (
  input  wire logic                  clock,
  input  wire fault_sup_pkg::flags_t flags,
  output var fault_sup_pkg::flags_t  read_clear,
  output var logic                   chip_select_n,
  output var logic                   frame_bit_strobe,
  output var logic                   crc_fail_strobe
);
  import fault_sup_pkg::*;
  initial begin
    read_clear = '0;
    chip_select_n = 1'b1;
    frame_bit_strobe = 1'b0;
    crc_fail_strobe = 1'b0;
  end
  // clears exactly what the read returned
  task automatic read_status(output flags_t got);
    @(negedge clock);
    got = flags;
    read_clear = flags;
    @(negedge clock);
    read_clear = '0;
  endtask : read_status
  // crc verdict comes in the cycle after the last bit
  task automatic send_frame(input int nbits, input logic bad);
    @(negedge clock);
    chip_select_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      @(negedge clock);
      frame_bit_strobe = 1'b1;
      @(negedge clock);
      frame_bit_strobe = 1'b0;
    end
    crc_fail_strobe = bad;
    @(negedge clock);
    crc_fail_strobe = 1'b0;
    chip_select_n = 1'b1;
  endtask : send_frame
endmodule : host_ecu_model
`default_nettype wire

/* File: test/pixel_fault_supervisor_bench.sv */
// bench for the pixel fault supervisor
// assumes host_ecu_model answers reads and frames
`timescale 1ns/1ps
`default_nettype none
module pixel_fault_supervisor_bench;
  import fault_sup_pkg::*;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        temp_warn_pin, temp_shut_pin, temp_cmp_pin, cap_fail_pin;
  logic        on_overlap_strobe, off_overlap_strobe, dimming_counter_wrap;
  logic        supervise_en, drive_enable_set, chip_select_n;
  logic        frame_bit_strobe, crc_fail_strobe, die_heat_compare_out;
  logic        global_switch_fault, status_fault_bit, switch_drive_enable;
  logic        switches_off, pattern_stop, fail_o, fail_oe_n;
  logic [2:0]  heat_compare_threshold, threshold_sel;
  logic [11:0] sw_short_pin, sw_open_pin, sw_overcur_pin, sw_gate_on;
  logic [11:0] switch_conducting_state;
  logic [35:0] switch_fault_state;
  logic [3:0]  string_ground_check_en, ground_loss_pin, string_ov_pin;
  flags_t      flags, read_clear, got;
  int          errors = 0;
  int          check_count = 0;
  int          fc_bits [4] = '{31, 32, 32, 33};
  pixel_fault_supervisor pixel_fault_supervisor_i (.clock, .arst_n,
    .temp_warn_pin, .temp_shut_pin, .temp_cmp_pin, .heat_compare_threshold,
    .chip_select_n, .frame_bit_strobe, .crc_fail_strobe, .on_overlap_strobe,
    .off_overlap_strobe, .sw_short_pin, .sw_open_pin, .sw_overcur_pin,
    .sw_gate_on, .string_ground_check_en, .ground_loss_pin, .string_ov_pin,
    .dimming_counter_wrap, .cap_fail_pin, .supervise_en, .drive_enable_set,
    .read_clear, .die_heat_compare_out, .threshold_sel, .flags,
    .global_switch_fault, .status_fault_bit, .switch_conducting_state,
    .switch_fault_state, .switch_drive_enable, .switches_off, .pattern_stop,
    .fail_o, .fail_oe_n);
  host_ecu_model host_ecu_model_i (.clock, .flags, .read_clear,
    .chip_select_n, .frame_bit_strobe, .crc_fail_strobe);
  always #20 clock = ~clock;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  task automatic wrap_up;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  // one-cycle pulse on a bench strobe
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(4);
  endtask : pulse
  // re-arm drive, then wait bounded for the healthy fail level
  task automatic restart;
    tick(4);
    pulse(drive_enable_set);
    for (int i = 0; i < 20 && fail_oe_n !== 1'b0; i++) tick(1);
    check({switch_drive_enable, switches_off, fail_oe_n}, 3'b100);
  endtask : restart
  // hang guard, about 25000 cycles
  initial begin
    #1ms;
    errors++;
    wrap_up();
  end
  initial begin
    {temp_warn_pin, temp_shut_pin, temp_cmp_pin, cap_fail_pin} = '0;
    {on_overlap_strobe, off_overlap_strobe, dimming_counter_wrap} = '0;
    {supervise_en, drive_enable_set, sw_short_pin, sw_open_pin} = '0;
    {sw_overcur_pin, sw_gate_on, string_ground_check_en} = '0;
    {ground_loss_pin, string_ov_pin, heat_compare_threshold} = '0;
    tick(5);
    check({switches_off, fail_oe_n, fail_o}, 3'b110);
    arst_n = 1'b1;
    host_ecu_model_i.read_status(got);
    check(got.powerup, 1'b1);
    tick(1);
    check(flags.powerup, 1'b0);
    for (int t = 0; t < 8; t++) begin
      heat_compare_threshold = t[2:0];
      temp_cmp_pin = t[0];
      tick(4);
      check({threshold_sel, die_heat_compare_out}, {t[2:0], t[0]});
    end
    supervise_en = 1'b1;
    restart();
    // frame length and crc table
    foreach (fc_bits[i]) begin
      host_ecu_model_i.send_frame(fc_bits[i], i == 2);
      tick(2);
      host_ecu_model_i.read_status(got);
      check(got.frame_check, fc_bits[i] != 32 || i == 2);
    end
    pulse(dimming_counter_wrap);
    host_ecu_model_i.read_status(got);
    check(got.counter_wrap, 1'b1);
    host_ecu_model_i.read_status(got);
    check(got.counter_wrap, 1'b0);
    sw_gate_on = 12'h001;
    pulse(off_overlap_strobe);
    check({flags.off_overlap, switches_off}, 2'b10);
    check({switch_fault_state[2:0], switch_conducting_state[0]}, 4'hf);
    pulse(on_overlap_strobe);
    check({flags.on_overlap, pattern_stop, switch_drive_enable}, 3'b110);
    check({switches_off, fail_oe_n}, 2'b11);
    host_ecu_model_i.read_status(got);
    restart();
    // ground loss is ignored until its string is enabled
    ground_loss_pin = 4'h2;
    tick(6);
    check({flags.ground_loss, global_switch_fault}, 5'h00);
    string_ground_check_en = 4'h2;
    tick(6);
    check({flags.ground_loss, global_switch_fault}, 5'h05);
    check({status_fault_bit, switches_off, fail_oe_n}, 3'b111);
    check(switch_drive_enable, 1'b0);
    ground_loss_pin = 4'h0;
    tick(4);
    host_ecu_model_i.read_status(got);
    restart();
    // thermal: warning, shutdown held while hot, hysteresis
    temp_warn_pin = 1'b1;
    tick(5);
    check(flags.thermal_warning, 1'b1);
    temp_shut_pin = 1'b1;
    tick(6);
    check({flags.overheat_shutdown, switches_off, fail_oe_n}, 3'b111);
    host_ecu_model_i.read_status(got);
    tick(1);
    check(flags.overheat_shutdown, 1'b1);
    temp_shut_pin = 1'b0;
    tick(5);
    host_ecu_model_i.read_status(got);
    tick(6);
    check(switches_off, 1'b1);
    temp_warn_pin = 1'b0;
    tick(5);
    host_ecu_model_i.read_status(got);
    restart();
    {sw_short_pin[1], sw_open_pin[2]} = 2'b11;
    tick(6);
    check(switch_fault_state[8:3], 6'b010_001);
    check({global_switch_fault, switches_off, fail_oe_n}, 3'b111);
    {sw_short_pin[1], sw_open_pin[2]} = 2'b00;
    tick(5);
    restart();
    // cap charge, string overvoltage, then overcurrent
    cap_fail_pin = 1'b1;
    tick(6);
    check({flags.charge_cap, global_switch_fault, fail_oe_n}, 3'b111);
    cap_fail_pin = 1'b0;
    tick(4);
    host_ecu_model_i.read_status(got);
    restart();
    string_ov_pin = 4'h4;
    tick(6);
    check({flags.overvoltage, global_switch_fault, switch_drive_enable},
          3'b110);
    string_ov_pin = 4'h0;
    tick(4);
    host_ecu_model_i.read_status(got);
    restart();
    sw_overcur_pin = 12'h008;
    tick(6);
    check({global_switch_fault, switches_off}, 2'b11);
    wrap_up();
  end
endmodule : pixel_fault_supervisor_bench
`default_nettype wire
